// >>> src/acr_config_regs.sv
// register bank holding power, reference, data rate and lane clock settings
// assumes an APB master on mclk; outputs feed the converter core as static levels
// Summary of operation
// - bit 12 picks lane dependent clock setting
// - bits 9-7 give averaging output clock
// - channel powerdown field decodes A, B, both
// - bit 11 turns internal reference off
// - bit 8 zero DDR, one SDR
// - bit 0 lane dependent clock setting
// - bit 0 powers down whole chip
// - all fields clear to zero on reset
// - bits 3-2 lane clock: two-lane or other
`timescale 1ns/1ps
module acr_config_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output acr_pkg::acr_ctrl_t ctrl
);
	import acr_pkg::*;

	logic rstSync1_q;
	logic rstSync2_q;
	logic rstInt_n;
	acr_state_t s_q;
	acr_state_t s_d;
	logic access;
	logic hit;
	logic [7:0] idx;

	// reset enters asynchronously but is released through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_q <= 1'b0;
			rstSync2_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSync2_q <= rstSync1_q;
		end
	end
	assign rstInt_n = rstSync2_q;

	// merges the two byte lanes that carry a 16-bit register
	function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) r[7:0] = wd[7:0];
		if (strb[1]) r[15:8] = wd[15:8];
		return r;
	endfunction

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign access = psel && penable;
	assign idx = paddr[9:2];
	assign hit = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0) &&
		(idx == IDX_CHAN_PWR_CLK || idx == IDX_REF_RATE || idx == IDX_AVG_CHIP_PWR || idx == IDX_LANE_CLK);
	// unmapped addresses answer with an error and change nothing
	assign pslverr = access && !hit;

	// next state: writes store every bit, reserved ones too, so read back is exact
	always_comb begin
		s_d = s_q;
		if (access && hit && pwrite) begin
			case (idx)
				IDX_CHAN_PWR_CLK: s_d.chanPwrClk = mergeLanes(s_q.chanPwrClk, pwdata, pstrb);
				IDX_REF_RATE: s_d.refRate = mergeLanes(s_q.refRate, pwdata, pstrb);
				IDX_AVG_CHIP_PWR: s_d.avgChipPwr = mergeLanes(s_q.avgChipPwr, pwdata, pstrb);
				IDX_LANE_CLK: s_d.laneClk = mergeLanes(s_q.laneClk, pwdata, pstrb);
				default: s_d = s_q;
			endcase
		end
		// read data registered in the setup cycle, so it is valid in the access cycle
		if (psel && !penable && !pwrite) begin
			case (idx)
				IDX_CHAN_PWR_CLK: s_d.prdata = {16'h0000, s_q.chanPwrClk};
				IDX_REF_RATE: s_d.prdata = {16'h0000, s_q.refRate};
				IDX_AVG_CHIP_PWR: s_d.prdata = {16'h0000, s_q.avgChipPwr};
				IDX_LANE_CLK: s_d.prdata = {16'h0000, s_q.laneClk};
				default: s_d.prdata = 32'h00000000;
			endcase
			// misaligned or aliased places read as zero, not as the register they overlap
			if (!hit) s_d.prdata = 32'h00000000;
		end
	end

	// all fields clear on reset: normal operation, internal reference, DDR
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			s_q <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL, 32'h00000000};
		end else begin
			s_q <= s_d;
		end
	end
	assign prdata = s_q.prdata;

	// decoded settings; combinational decode of flop outputs, no further registers
	always_comb begin
		ctrl.laneClockSelectA = s_q.chanPwrClk[POS_LANE_CLK_A];
		// averaging only counts as on when all three setup fields hold enabling values
		ctrl.averagingEnable = (s_q.chanPwrClk[POS_AVG_A_LO+:2] == AVG_A_ON) &&
			(s_q.avgChipPwr[POS_AVG_B_LO+:2] == AVG_B_ON) && (s_q.avgChipPwr[POS_AVG_C] == AVG_C_ON);
		ctrl.averagingOutputClockCfg = s_q.chanPwrClk[POS_AVG_CLK_LO+:3];
		ctrl.adcAPowerdown = s_q.chanPwrClk[POS_CHAN_PD_LO];
		ctrl.adcBPowerdown = s_q.chanPwrClk[POS_CHAN_PD_LO+1];
		ctrl.internalReferenceOff = s_q.refRate[POS_REF_OFF];
		ctrl.internalReferenceOn = !s_q.refRate[POS_REF_OFF];
		ctrl.singleDataRate = s_q.refRate[POS_RATE_SDR];
		ctrl.laneClockSelectB = s_q.refRate[POS_LANE_CLK_B];
		ctrl.fullChipPowerdown = s_q.avgChipPwr[POS_CHIP_PD];
		ctrl.laneClockSelectC = s_q.laneClk[POS_LANE_CLK_C];
		ctrl.laneClockSelectD = s_q.laneClk[POS_LANE_CLK_D_LO+:2];
		ctrl.laneD24bTwoLane = (s_q.laneClk[POS_LANE_CLK_D_LO+:2] == LANE_D_24B2L);
	end

	// a full-strobe write to the reference register is stored in it by the next cycle
	a_write_readback: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(access && hit && pwrite && pstrb == 4'hF && idx == IDX_REF_RATE) |=> (s_q.refRate == $past(pwdata[15:0])))
		else $error("reference register did not store written data");
	a_chan_pd_decode: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(s_q.chanPwrClk[1:0] == 2'h3) |-> (ctrl.adcAPowerdown && ctrl.adcBPowerdown))
		else $error("both-channel powerdown not decoded");
	a_chan_pd_a: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(s_q.chanPwrClk[1:0] == 2'h1) |-> (ctrl.adcAPowerdown && !ctrl.adcBPowerdown))
		else $error("channel A powerdown not decoded");
	a_chan_pd_b: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(s_q.chanPwrClk[1:0] == 2'h2) |-> (!ctrl.adcAPowerdown && ctrl.adcBPowerdown))
		else $error("channel B powerdown not decoded");
	a_ref_select: assert property (@(posedge mclk) disable iff (!rstInt_n)
		ctrl.internalReferenceOn != s_q.refRate[11])
		else $error("reference selection wrong");
	a_rate_select: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(access && hit && pwrite && pstrb[1] && idx == IDX_REF_RATE) |=> (ctrl.singleDataRate == $past(pwdata[8])))
		else $error("data rate did not follow write");
	a_chip_pd: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(access && hit && pwrite && pstrb[0] && idx == IDX_AVG_CHIP_PWR) |=> (ctrl.fullChipPowerdown == $past(pwdata[0])))
		else $error("chip powerdown did not follow write");
	a_avg_enable: assert property (@(posedge mclk) disable iff (!rstInt_n)
		ctrl.averagingEnable |-> (s_q.chanPwrClk[11:10] == 2'h1 && s_q.avgChipPwr[5:4] == 2'h2 && s_q.avgChipPwr[1]))
		else $error("averaging enabled without setup values");
	a_avg_clock: assert property (@(posedge mclk) disable iff (!rstInt_n)
		ctrl.averagingOutputClockCfg == s_q.chanPwrClk[9:7])
		else $error("averaging clock field misplaced");
	a_lane_select: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(ctrl.laneClockSelectA == s_q.chanPwrClk[12]) && (ctrl.laneClockSelectB == s_q.refRate[0]))
		else $error("lane clock select misplaced");
	a_lane_d: assert property (@(posedge mclk) disable iff (!rstInt_n)
		ctrl.laneD24bTwoLane == (s_q.laneClk[3:2] == 2'h0))
		else $error("lane clock d decode wrong");
	a_reset_clear: assert property (@(posedge mclk)
		$rose(rstInt_n) |-> (s_q.chanPwrClk == 16'h0000 && s_q.refRate == 16'h0000 && !ctrl.singleDataRate))
		else $error("registers not cleared by reset");
	a_unmapped_err: assert property (@(posedge mclk) disable iff (!rstInt_n)
		(access && !hit) |-> pslverr ##1 ($stable(s_q.chanPwrClk) && $stable(s_q.refRate) &&
			$stable(s_q.avgChipPwr) && $stable(s_q.laneClk)))
		else $error("unmapped access changed state");
endmodule

// >>> shared/acr_pkg.sv
// package for the converter power and interface configuration register bank
// assumes an APB master with 32-bit data; registers are 16 bits in the low half
package acr_pkg;
	localparam int ADDR_W = 12;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_CHAN_PWR_CLK = 8'hC0;
	localparam logic [7:0] IDX_REF_RATE = 8'hC1;
	localparam logic [7:0] IDX_AVG_CHIP_PWR = 8'hC4;
	localparam logic [7:0] IDX_LANE_CLK = 8'hC5;
	localparam logic [15:0] RESET_VAL = 16'h0000;
	// field positions
	localparam int POS_LANE_CLK_A = 12;
	localparam int POS_AVG_A_LO = 10;
	localparam int POS_AVG_CLK_LO = 7;
	localparam int POS_CHAN_PD_LO = 0;
	localparam int POS_REF_OFF = 11;
	localparam int POS_RATE_SDR = 8;
	localparam int POS_LANE_CLK_B = 0;
	localparam int POS_AVG_B_LO = 4;
	localparam int POS_AVG_C = 1;
	localparam int POS_CHIP_PD = 0;
	localparam int POS_LANE_CLK_C = 9;
	localparam int POS_LANE_CLK_D_LO = 2;
	// enabling values of the averaging setup fields, and the two-lane lane clock code
	localparam logic [1:0] AVG_A_ON = 2'h1;
	localparam logic [1:0] AVG_B_ON = 2'h2;
	localparam logic AVG_C_ON = 1'b1;
	localparam logic [1:0] LANE_D_24B2L = 2'h0;

	typedef struct packed {
		logic [15:0] chanPwrClk;
		logic [15:0] refRate;
		logic [15:0] avgChipPwr;
		logic [15:0] laneClk;
		logic [31:0] prdata;
	} acr_state_t;

	// decoded controls that leave the bank
	typedef struct packed {
		logic laneClockSelectA;
		logic averagingEnable;
		logic [2:0] averagingOutputClockCfg;
		logic adcAPowerdown;
		logic adcBPowerdown;
		logic internalReferenceOff;
		logic internalReferenceOn;
		logic singleDataRate;
		logic laneClockSelectB;
		logic fullChipPowerdown;
		logic laneClockSelectC;
		logic [1:0] laneClockSelectD;
		logic laneD24bTwoLane;
	} acr_ctrl_t;
endpackage

// >>> sim/acr_config_regs_test.sv
// self-checking bench for the converter configuration register bank
// assumes zero-wait APB slave; ctrl levels settle one edge after a write
`timescale 1ns/1ps
module acr_config_regs_test;
	import acr_pkg::*;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [3:0] pstrb;
	acr_ctrl_t ctrl;
	logic [15:0] mdl [4];
	int failCount = 0;
	int checked = 0;
	localparam logic [7:0] IDX [4] = '{IDX_CHAN_PWR_CLK, IDX_REF_RATE, IDX_AVG_CHIP_PWR, IDX_LANE_CLK};
	// defined fields only, so reserved bits stay zero as the host must keep them
	localparam logic [15:0] MASK [4] = '{16'h1F83, 16'h0901, 16'h0033, 16'h020C};
	acr_config_regs dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.ctrl(ctrl));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	function automatic logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected decode, worked out from the field map
	function automatic acr_ctrl_t expCtrl();
		acr_ctrl_t c;
		c.laneClockSelectA = mdl[0][12];
		c.averagingEnable = mdl[0][11:10] == 2'h1 && mdl[2][5:4] == 2'h2 && mdl[2][1];
		c.averagingOutputClockCfg = mdl[0][9:7];
		c.adcAPowerdown = mdl[0][0];
		c.adcBPowerdown = mdl[0][1];
		c.internalReferenceOff = mdl[1][11];
		c.internalReferenceOn = !mdl[1][11];
		c.singleDataRate = mdl[1][8];
		c.laneClockSelectB = mdl[1][0];
		c.fullChipPowerdown = mdl[2][0];
		c.laneClockSelectC = mdl[3][9];
		c.laneClockSelectD = mdl[3][3:2];
		c.laneD24bTwoLane = mdl[3][3:2] == 2'h0;
		return c;
	endfunction
	task automatic tallyAndFinish();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one APB transfer; read data and response taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failCount++;
			tallyAndFinish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wrReg(input int i, input logic [15:0] v, input logic [3:0] s);
		apb(1'b1, {2'b00, IDX[i], 2'b00}, {nextRand() & 32'hFFFF0000} | {16'h0000, v}, s);
		if (s[0]) mdl[i][7:0] = v[7:0];
		if (s[1]) mdl[i][15:8] = v[15:8];
	endtask
	task automatic rdChk(input int i);
		apb(1'b0, {2'b00, IDX[i], 2'b00}, nextRand(), 4'h0);
		chk("readback", rd, {16'h0000, mdl[i]});
	endtask
	initial begin
		logic [31:0] r;
		logic [15:0] v;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		rst_n = 1'b0;
		seed = 32'h55BEBD6E;
		foreach (mdl[k]) mdl[k] = RESET_VAL;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("ctrl reset", 32'(ctrl), 32'(expCtrl()));
		for (int i = 0; i < 4; i++) rdChk(i);
		wrReg(0, 16'h0400, 4'h3);
		wrReg(2, 16'h0022, 4'h3);
		@(negedge mclk);
		chk("averaging on", 32'(ctrl.averagingEnable), 32'h1);
		wrReg(2, 16'h0020, 4'h3);
		@(negedge mclk);
		chk("averaging off", 32'(ctrl.averagingEnable), 32'h0);
		// random fields and strobes; channel powerdown walks all four codes
		for (int k = 0; k < 48; k++) begin
			r = nextRand();
			v = r[15:0] & MASK[k % 4];
			if (k % 4 == 0) v[1:0] = 2'(k >> 2);
			wrReg(k % 4, v, (k < 16) ? 4'h3 : r[19:16]);
			rdChk(k % 4);
			@(negedge mclk);
			chk("ctrl", 32'(ctrl), 32'(expCtrl()));
		end
		// unmapped, aliased and misaligned places refuse and leave the bank alone
		apb(1'b1, 12'h308, 32'h0000FFFF, 4'hF);
		chk("slverr", 32'(err), 32'h1);
		apb(1'b1, 12'hB00, 32'h0000FFFF, 4'hF);
		chk("slverr", 32'(err), 32'h1);
		apb(1'b0, 12'h301, 32'h0, 4'h0);
		chk("unmapped read", rd, 32'h0);
		for (int i = 0; i < 4; i++) rdChk(i);
		tallyAndFinish();
	end
endmodule
